// >>> inc/ndc_regs.svh
`ifndef NDC_REGS_SVH
`define NDC_REGS_SVH
// Register byte addresses
`define NDC_ADDR_CTRL   12'h000
`define NDC_ADDR_AHIGH  12'h004
`define NDC_ADDR_ALOW   12'h008
`define NDC_ADDR_DATA   12'h00c
`define NDC_ADDR_STAT   12'h010
// Control register fields
`define NDC_B_TRIG      0
`define NDC_B_READ_ENABLE      1
`define NDC_B_PGO       2
`define NDC_B_PARM      3
`define NDC_B_MODE      4
`define NDC_B_CGO       5
`define NDC_B_CARM      6
`define NDC_B_CTS       7
// Status fields
`define NDC_B_DONE      0
`define NDC_B_BUSY      1
// Reset value and page offset limit
`define NDC_CTRL_RST    8'h00
`define NDC_OFS_MAX     4'hf
// Timing: read latency and erase times
`define NDC_READ_CYC    3'h3
`define NDC_ERASE0_US   3200
`define NDC_ERASE1_US   3700
`define NDC_CLK_MHZ     20
`endif

// >>> inc/ndc_pkg.sv
package ndc_pkg;
    typedef enum logic [1:0]
    {
        NDC_IDLE  = 2'b00,
        NDC_READ  = 2'b01,
        NDC_ERASE = 2'b11
    } ndc_state_t;
endpackage : ndc_pkg

// >>> rtl/ndc_ctrl.sv
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// - Read trigger is ignored unless read enable is already set.
// - Hardware clears read trigger when the read cycle completes.
// - Read enable low blocks every read of the array.
// - Mode low gives byte reads; high gives page reads or page erase.
// - Byte mode loads the data register, then clears read trigger.
// - Data register holds its value until another read or write.
// - Page read loads data, bumps the offset, then clears trigger.
// - A page read covers at most sixteen bytes from the start address.
// - Page bits never increment; offset saturates at 0fh.
// - Mode high supports erasing a sixteen byte page.
// - Tag buffer clears at reset and on clear arm falling only.
// - Erase mode data writes tag the address and bump the offset.
// - Erase is timed internally; end clears clear go, raises event.
// - Hardware clears clear arm when the erase finishes.
// - Erased locations read back as zero.
// - Clear go is ignored unless clear arm was already set.
// - Cycle time select picks 3.2 ms or 3.7 ms erase time.
// - Done flag sets at erase end and stays until software clears.
`include "ndc_regs.svh"
module ndc_ctrl
    import ndc_pkg::*;
#(
    parameter int ERASE0_CYC = `NDC_ERASE0_US * `NDC_CLK_MHZ,
    parameter int ERASE1_CYC = `NDC_ERASE1_US * `NDC_CLK_MHZ
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             eraseDone
);

    // ==============================================================
    // Storage and state
    logic [7:0]  memArray [0:2047];
    logic [15:0] tagBuf;
    logic [7:0]  ctrl;
    logic [2:0]  addrHigh;
    logic [7:0]  addrLow;
    logic [7:0]  nvmData;
    logic        doneFlag;
    ndc_state_t  state;
    logic [2:0]  readCnt;
    logic [17:0] eraseCnt;
    logic        wrAcc;
    logic        rdAcc;
    logic        ctrlWr;
    logic        dataWr;
    logic        readStart;
    logic        eraseStart;
    logic        readEnd;
    logic        eraseEnd;
    logic        pageMode;
    logic [3:0]  offset;
    logic [10:0] curAddr;
    logic [7:0]  next_ctrl;

    // ==============================================================
    // APB decode
    assign pready  = 1'b1;
    assign wrAcc   = psel && penable && pwrite;
    assign rdAcc   = psel && penable && !pwrite;
    assign ctrlWr  = wrAcc && (paddr == `NDC_ADDR_CTRL);
    assign dataWr  = wrAcc && (paddr == `NDC_ADDR_DATA);
    assign pageMode = ctrl[`NDC_B_MODE];
    assign offset  = addrLow[3:0];
    assign curAddr = {addrHigh, addrLow};

    // Unmapped addresses answer with an error
    always_comb
    begin
        pslverr = 1'b0;
        if (psel && penable && (paddr > `NDC_ADDR_STAT || paddr[1:0] != 2'h0))
        begin
            pslverr = 1'b1;
        end
    end

    // Read data mux, registered
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == `NDC_ADDR_CTRL)
                prdata <= {24'h0, ctrl};
            else if (paddr == `NDC_ADDR_AHIGH)
                prdata <= {29'h0, addrHigh};
            else if (paddr == `NDC_ADDR_ALOW)
                prdata <= {24'h0, addrLow};
            else if (paddr == `NDC_ADDR_DATA)
                prdata <= {24'h0, nvmData};
            else if (paddr == `NDC_ADDR_STAT)
                prdata <= {30'h0, state != NDC_IDLE, doneFlag};
            else
                prdata <= 32'h0;
        end
    end

    // ==============================================================
    // Start conditions
    // Trigger needs read enable already set and no erase running
    assign readStart = ctrlWr && pwdata[`NDC_B_TRIG] && !ctrl[`NDC_B_TRIG]
                       && ctrl[`NDC_B_READ_ENABLE] && state == NDC_IDLE;
    // Go needs clear arm set by an earlier write
    assign eraseStart = ctrlWr && pwdata[`NDC_B_CGO] && ctrl[`NDC_B_CARM]
                        && pageMode && state == NDC_IDLE;
    assign readEnd  = state == NDC_READ && readCnt == 3'h0;
    assign eraseEnd = state == NDC_ERASE && eraseCnt == 18'h0;

    // ==============================================================
    // Sequencer
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state    <= NDC_IDLE;
            readCnt  <= 3'h0;
            eraseCnt <= 18'h0;
        end
        else
        begin
            case (state)
                NDC_IDLE:
                begin
                    if (readStart)
                    begin
                        state   <= NDC_READ;
                        readCnt <= `NDC_READ_CYC;
                    end
                    else if (eraseStart)
                    begin
                        state    <= NDC_ERASE;
                        eraseCnt <= pwdata[`NDC_B_CTS] ? 18'(ERASE1_CYC - 1)
                                                       : 18'(ERASE0_CYC - 1);
                    end
                end
                NDC_READ:
                begin
                    if (readEnd)
                        state <= NDC_IDLE;
                    else
                        readCnt <= readCnt - 3'h1;
                end
                NDC_ERASE:
                begin
                    if (eraseEnd)
                        state <= NDC_IDLE;
                    else
                        eraseCnt <= eraseCnt - 18'h1;
                end
                default:
                    state <= NDC_IDLE;
            endcase
        end
    end

    // ==============================================================
    // Control register with hardware clears
    always_comb
    begin
        next_ctrl = ctrl;
        if (ctrlWr)
        begin
            next_ctrl = pwdata[7:0];
            if (!readStart)
                next_ctrl[`NDC_B_TRIG] = ctrl[`NDC_B_TRIG] && pwdata[`NDC_B_TRIG];
            if (!eraseStart)
                next_ctrl[`NDC_B_CGO] = ctrl[`NDC_B_CGO] && pwdata[`NDC_B_CGO];
            next_ctrl[`NDC_B_PGO] = 1'b0;
        end
        if (readEnd)
            next_ctrl[`NDC_B_TRIG] = 1'b0;
        if (eraseEnd)
        begin
            next_ctrl[`NDC_B_CGO]  = 1'b0;
            next_ctrl[`NDC_B_CARM] = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ctrl <= `NDC_CTRL_RST;
        else
            ctrl <= next_ctrl;
    end

    // ==============================================================
    // Address registers with page offset increment
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            addrHigh <= 3'h0;
            addrLow  <= 8'h0;
        end
        else if (wrAcc && paddr == `NDC_ADDR_AHIGH)
            addrHigh <= pwdata[2:0];
        else if (wrAcc && paddr == `NDC_ADDR_ALOW)
            addrLow <= pwdata[7:0];
        else if (((readEnd) || (dataWr && ctrl[`NDC_B_CARM] == 1'b0 && state == NDC_IDLE))
                 && pageMode && offset != `NDC_OFS_MAX)
            addrLow[3:0] <= offset + 4'h1;
    end

    // ==============================================================
    // Data register: loaded by a read, or by a software write
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            nvmData <= 8'h0;
        else if (readEnd)
            nvmData <= memArray[curAddr];
        else if (dataWr)
            nvmData <= pwdata[7:0];
    end

    // ==============================================================
    // Tag buffer: set by page mode data writes, cleared on arm fall
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tagBuf <= 16'h0;
        else if (ctrl[`NDC_B_CARM] && !next_ctrl[`NDC_B_CARM])
            tagBuf <= 16'h0;
        else if (dataWr && pageMode && state == NDC_IDLE && !ctrl[`NDC_B_CARM])
            tagBuf[offset] <= 1'b1;
    end

    // Array erase of tagged locations at the end of the erase time
    always_ff @(posedge mclk)
    begin
        if (eraseEnd)
        begin
            for (int i = 0; i < 16; i++)
                if (tagBuf[i])
                    memArray[{addrHigh, addrLow[7:4], 4'(i)}] <= 8'h0;
        end
    end

    // ==============================================================
    // Done flag: set wins over a software clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            doneFlag <= 1'b0;
        else if (eraseEnd)
            doneFlag <= 1'b1;
        else if (wrAcc && paddr == `NDC_ADDR_STAT && pwdata[`NDC_B_DONE])
            doneFlag <= 1'b0;
    end

    // Completion event pulse
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            eraseDone <= 1'b0;
        else
            eraseDone <= eraseEnd;
    end

    // ==============================================================
    // Checks
    sequence s_readArmed;
        ctrlWr && pwdata[`NDC_B_TRIG] && !ctrl[`NDC_B_TRIG] && ctrl[`NDC_B_READ_ENABLE]
        && state == NDC_IDLE;
    endsequence

    a_trig_no_enable: assert property (@(posedge mclk) disable iff (rst)
        ctrlWr && pwdata[`NDC_B_TRIG] && !ctrl[`NDC_B_READ_ENABLE] |=> state != NDC_READ)
        else $error("read started without read enable");

    a_trig_self_clear: assert property (@(posedge mclk) disable iff (rst)
        s_readArmed |=> ctrl[`NDC_B_TRIG] [*4] ##1 !ctrl[`NDC_B_TRIG])
        else $error("read trigger did not clear on time");

    a_read_data_load: assert property (@(posedge mclk) disable iff (rst)
        readEnd |=> nvmData == $past(memArray[curAddr]))
        else $error("data register not loaded at read end");

    a_data_holds: assert property (@(posedge mclk) disable iff (rst)
        !readEnd && !dataWr |=> $stable(nvmData))
        else $error("data register changed without access");

    a_page_offset_step: assert property (@(posedge mclk) disable iff (rst)
        readEnd && pageMode && offset != `NDC_OFS_MAX |=> offset == $past(offset) + 4'h1)
        else $error("page offset did not advance");

    a_offset_saturates: assert property (@(posedge mclk) disable iff (rst)
        (readEnd || dataWr) && pageMode && offset == `NDC_OFS_MAX
        && !(wrAcc && paddr == `NDC_ADDR_ALOW) |=> offset == `NDC_OFS_MAX)
        else $error("page offset rolled over");

    a_go_needs_arm: assert property (@(posedge mclk) disable iff (rst)
        ctrlWr && pwdata[`NDC_B_CGO] && !ctrl[`NDC_B_CARM] |=> state != NDC_ERASE)
        else $error("erase started without clear arm");

    a_erase_end_bits: assert property (@(posedge mclk) disable iff (rst)
        eraseEnd |=> !ctrl[`NDC_B_CGO] && !ctrl[`NDC_B_CARM] && eraseDone && doneFlag)
        else $error("erase end effects missing");

    a_tag_clear: assert property (@(posedge mclk) disable iff (rst)
        ctrl[`NDC_B_CARM] && !next_ctrl[`NDC_B_CARM] |=> tagBuf == 16'h0)
        else $error("tag buffer not cleared on arm fall");

    a_no_read_in_erase: assert property (@(posedge mclk) disable iff (rst)
        state == NDC_ERASE && ctrlWr && pwdata[`NDC_B_TRIG] && !ctrl[`NDC_B_TRIG]
        |=> !ctrl[`NDC_B_TRIG] && state != NDC_READ)
        else $error("read began during erase");

endmodule : ndc_ctrl

// >>> testbench/test_data_nvm_read_erase_ctrl.sv
`timescale 1ns/1ns
`include "ndc_regs.svh"
module test_data_nvm_read_erase_ctrl
    import ndc_pkg::*;
;
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, eraseDone;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    int          n_fail, checked, n;
    // Row: address, written value, expected read-back, expected error
    typedef struct { logic [11:0] a; logic [31:0] w, e; logic x; } ndc_row_t;
    ndc_row_t rows [6] = '{
        '{`NDC_ADDR_AHIGH, 32'h000000ff, 32'h00000007, 1'b0},
        '{`NDC_ADDR_ALOW,  32'h000000a5, 32'h000000a5, 1'b0},
        '{`NDC_ADDR_CTRL,  32'h00000001, 32'h00000000, 1'b0},
        '{`NDC_ADDR_CTRL,  32'h00000030, 32'h00000010, 1'b0},
        '{`NDC_ADDR_CTRL,  32'h00000000, 32'h00000000, 1'b0},
        '{12'h014,         32'h00000000, 32'h00000000, 1'b1}};

    ndc_ctrl #(.ERASE0_CYC(20), .ERASE1_CYC(30)) i_ndc_ctrl
    (
        .mclk      (mclk),
        .rst       (rst),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .eraseDone (eraseDone)
    );

    // ==========================================================
    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ==========================================================
    // Tasks
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1)
        begin
            n_fail++;
            $display("mismatch pready expected 1 seen %b", pready);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Read one register and compare the whole word with a zero-extended byte
    task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, {24'h0, e}, rd);
    endtask : rchk

    // Trigger a read and poll until the trigger bit clears
    task automatic do_read(input logic [7:0] c);
        apb(1'b1, `NDC_ADDR_CTRL, {24'h0, c | 8'h01});
        for (int k = 0; k < 20; k++)
        begin
            apb(1'b0, `NDC_ADDR_CTRL, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
        chk("ctrl after read", {24'h0, c}, rd);
    endtask : do_read

    // Tag three bytes ending at the page boundary, erase, time it
    task automatic erase(input logic c);
        logic [7:0] m;
        m = {c, 7'h10};
        apb(1'b1, `NDC_ADDR_CTRL, {24'h0, m});
        apb(1'b1, `NDC_ADDR_AHIGH, 32'h2);
        apb(1'b1, `NDC_ADDR_ALOW, 32'h0d);
        repeat (3) apb(1'b1, `NDC_ADDR_DATA, 32'h5a);
        rchk("offset saturated", `NDC_ADDR_ALOW, 8'h0f);
        rchk("page kept", `NDC_ADDR_AHIGH, 8'h02);
        apb(1'b1, `NDC_ADDR_CTRL, {24'h0, m | 8'h40});
        apb(1'b1, `NDC_ADDR_CTRL, {24'h0, m | 8'h60});
        // Trigger a read while the erase runs; it must be refused
        apb(1'b1, `NDC_ADDR_CTRL, {24'h0, m | 8'h62});
        apb(1'b1, `NDC_ADDR_CTRL, {24'h0, m | 8'h63});
        n = 6;  // The two transfers above take three edges each
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (eraseDone !== 1'b1 && n < 200);
        checked++;
        if (n < (c ? 29 : 19) || n > (c ? 34 : 24))
        begin
            n_fail++;
            $display("mismatch erase cycles expected %0d seen %0d", c ? 30 : 20, n);
        end
        rchk("ctrl after erase", `NDC_ADDR_CTRL, m | 8'h02);
        rchk("done flag", `NDC_ADDR_STAT, 8'h01);
        apb(1'b1, `NDC_ADDR_STAT, 32'h1);
        rchk("done cleared", `NDC_ADDR_STAT, 8'h00);
    endtask : erase

    // Print counts and verdict, end the run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Watchdog
    initial
    begin
        #2000000;
        n_fail++;
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h0;
        pwdata = 32'h0;
        n_fail = 0;
        checked = 0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        // Reset values of every register
        for (int a = 0; a <= 16; a += 4)
            rchk("reset value", a[11:0], 8'h00);
        // Table of write and read-back rows
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0);
            chk("slave error", {31'h0, rows[i].x}, {31'h0, err});
            if (!rows[i].x)
                chk("read back", rows[i].e, rd);
        end
        rchk("no erase without arm", `NDC_ADDR_STAT, 8'h00);
        // Erase with both cycle time settings
        erase(1'b0);
        erase(1'b1);
        // Page read walks the erased bytes, offset saturates
        apb(1'b1, `NDC_ADDR_CTRL, 32'h10);
        apb(1'b1, `NDC_ADDR_CTRL, 32'h12);
        apb(1'b1, `NDC_ADDR_ALOW, 32'h0d);
        for (int k = 0; k < 3; k++)
        begin
            do_read(8'h12);
            rchk("erased byte", `NDC_ADDR_DATA, 8'h00);
            rchk("page offset", `NDC_ADDR_ALOW, (k == 2) ? 8'h0f : 8'(8'h0e + k));
        end
        // Byte read keeps the offset
        apb(1'b1, `NDC_ADDR_CTRL, 32'h02);
        apb(1'b1, `NDC_ADDR_ALOW, 32'h0e);
        // A software write leaves a known value that the read must replace
        apb(1'b1, `NDC_ADDR_DATA, 32'h5a);
        rchk("data held", `NDC_ADDR_DATA, 8'h5a);
        do_read(8'h02);
        rchk("byte data", `NDC_ADDR_DATA, 8'h00);
        rchk("byte offset", `NDC_ADDR_ALOW, 8'h0e);
        // Read enable dropped: trigger refused
        apb(1'b1, `NDC_ADDR_CTRL, 32'h00);
        apb(1'b1, `NDC_ADDR_CTRL, 32'h01);
        rchk("trigger blocked", `NDC_ADDR_CTRL, 8'h00);
        // Second reset in mid-run
        apb(1'b1, `NDC_ADDR_CTRL, 32'h10);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rchk("ctrl after reset", `NDC_ADDR_CTRL, 8'h00);
        give_verdict();
    end
endmodule : test_data_nvm_read_erase_ctrl
